//--- core/rxm_client_out.sv
// receive client output stage: frame delimiting, flags and crc check
`timescale 1ns/1ps
module rxm_client_out
    import rxm_pkg::*;
#(
    parameter int WORDS = W_100G
)(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WORDS*64-1:0] inData,
    input wire logic [WORDS*8-1:0] inCtl,
    input wire logic inValid,
    input wire logic passThru,
    input wire logic [15:0] maxLen,
    output logic [WORDS*64-1:0] outData,
    output logic [WORDS*8-1:0] outCtl,
    output logic [WORDS-1:0] outFirst,
    output logic [WORDS*8-1:0] outLast,
    output logic [WORDS-1:0] outRunt,
    output logic [WORDS-1:0] outPayload,
    output logic outFcsError,
    output logic outFcsValid,
    output logic outValid,
    output logic rxError
);

    localparam int LANES = WORDS * WORD_LANES;

    generate
        if (!(WORDS == W_100G || WORDS == W_40G)) begin : g_check
            $error("rxm_client_out: WORDS must be 5 or 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // lane decode

    rxm_lane_s lane [LANES];

    generate
        for (genvar k = 0; k < LANES; k++) begin : g_lane
            rxm_lane_dec u_dec (
                .byteIn(inData[LANES*8-1-8*k -: 8]),
                .ctlIn(inCtl[LANES-1-k]),
                .lane(lane[k])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // frame tracking across lanes, first lane to last

    rxm_state_e frameSt;
    rxm_state_e next_frameSt;
    logic [15:0] lenRun;
    logic [15:0] next_lenRun;
    logic errRun;
    logic next_errRun;
    logic [31:0] crcRun;
    logic [31:0] next_crcRun;

    logic [LANES-1:0] contMask;
    logic [LANES-1:0] newMask;
    logic [LANES-1:0] startMask;
    logic [LANES-1:0] preMask;
    logic [LANES-1:0] sfdMask;
    logic [LANES-1:0] firstMask;
    logic newFrame;
    logic abortSeen;
    rxm_end_s endInfo;

    always_comb begin
        rxm_state_e st;
        logic [15:0] len;
        logic [2:0] pre;
        logic err;
        logic isNew;
        st = frameSt;
        len = lenRun;
        pre = 3'h0;
        err = errRun;
        isNew = 1'b0;
        contMask = '0;
        newMask = '0;
        startMask = '0;
        preMask = '0;
        sfdMask = '0;
        firstMask = '0;
        abortSeen = 1'b0;
        endInfo = '0;
        if (inValid) begin
            for (int k = 0; k < LANES; k++) begin
                if (lane[k].isStart && (k % WORD_LANES == 0)) begin
                    // a start inside a running frame cuts that frame short
                    if (st == ST_FRAME) begin
                        abortSeen = 1'b1;
                    end
                    st = ST_FRAME;
                    isNew = 1'b1;
                    len = 16'h0000;
                    err = 1'b0;
                    pre = PRE_CNT;
                    startMask[k] = 1'b1;
                end else if (pre != 3'h0) begin
                    pre = pre - 3'h1;
                    preMask[k] = 1'b1;
                    if (pre == 3'h0) begin
                        sfdMask[k] = 1'b1;
                    end
                end else if (st == ST_FRAME) begin
                    if (lane[k].isTerm) begin
                        // only one frame end per bus word is reported in full
                        if (endInfo.seen) begin
                            abortSeen = 1'b1;
                        end else begin
                            endInfo.seen = 1'b1;
                            endInfo.lane = 8'(k);
                            endInfo.len = len;
                            endInfo.isNew = isNew;
                            endInfo.err = err;
                        end
                        st = ST_IDLE;
                    end else if (lane[k].isData) begin
                        if (len == 16'h0000) begin
                            firstMask[k] = 1'b1;
                        end
                        if (len != 16'hffff) begin
                            len = len + 16'h0001;
                        end
                        if (isNew) begin
                            newMask[k] = 1'b1;
                        end else begin
                            contMask[k] = 1'b1;
                        end
                    end else if (lane[k].isErr) begin
                        err = 1'b1;
                    end else begin
                        abortSeen = 1'b1;
                        st = ST_IDLE;
                    end
                end
            end
        end
        newFrame = isNew;
        next_frameSt = st;
        next_lenRun = len;
        next_errRun = err;
    end

    ////////////////////////////////////////////////////////////////////////////
    // crc: one chain continues the old frame, one seeds a frame begun this word

    logic [31:0] crcCont;
    logic [31:0] crcNew;

    rxm_crc32 #(
        .LANES(LANES)
    ) u_crcCont (
        .seed(crcRun),
        .bytes(inData),
        .mask(contMask),
        .crc(crcCont)
    );

    rxm_crc32 #(
        .LANES(LANES)
    ) u_crcNew (
        .seed(CRC_INIT),
        .bytes(inData),
        .mask(newMask),
        .crc(crcNew)
    );

    always_comb begin
        next_crcRun = newFrame ? crcNew : crcCont;
        if (!inValid) begin
            next_crcRun = crcRun;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            frameSt <= ST_IDLE;
            lenRun <= 16'h0000;
            errRun <= 1'b0;
            crcRun <= CRC_INIT;
        end else begin
            frameSt <= next_frameSt;
            lenRun <= next_lenRun;
            errRun <= next_errRun;
            crcRun <= next_crcRun;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // end-of-frame verdict

    logic crcOk;
    logic hasLast;
    logic late;
    logic runtNow;
    logic errNow;
    int lastLane;

    always_comb begin
        crcOk = ((endInfo.isNew ? crcNew : crcCont) == CRC_RESIDUE);
        hasLast = endInfo.seen && (endInfo.len >= LAST_BACK_LEN);
        // last data byte sits four fcs bytes before the terminate
        lastLane = int'(endInfo.lane) - LAST_BACK;
        late = hasLast && (lastLane < 0);
        runtNow = endInfo.seen && (endInfo.len < MIN_FRAME) && (endInfo.len > DECODE_MAX);
        errNow = abortSeen || (endInfo.seen && (endInfo.err || !crcOk || (endInfo.len < MIN_FRAME)
                 || (endInfo.len > maxLen)));
    end

    ////////////////////////////////////////////////////////////////////////////
    // held stage: one word of look-behind so a late last byte can be marked

    logic [LANES*8-1:0] hD;
    logic [LANES*8-1:0] next_hD;
    logic [LANES-1:0] hC;
    logic [LANES-1:0] next_hC;
    logic [WORDS-1:0] hFirst;
    logic [WORDS-1:0] next_hFirst;
    logic [WORDS-1:0] hPay;
    logic [WORDS-1:0] next_hPay;
    logic [LANES-1:0] hLast;
    logic [LANES-1:0] next_hLast;
    logic [WORDS-1:0] hRunt;
    logic [WORDS-1:0] next_hRunt;
    logic hFcsV;
    logic next_hFcsV;
    logic hFcsE;
    logic next_hFcsE;
    logic hErr;
    logic next_hErr;

    always_comb begin
        logic [LANES-1:0] payMask;
        logic [LANES-1:0] headMask;
        payMask = contMask | newMask;
        headMask = passThru ? startMask : firstMask;
        if (passThru) begin
            payMask = payMask | startMask | preMask;
        end
        next_hD = hD;
        next_hC = hC;
        next_hFirst = hFirst;
        next_hPay = hPay;
        next_hLast = hLast;
        next_hRunt = hRunt;
        next_hFcsV = hFcsV;
        next_hFcsE = hFcsE;
        next_hErr = hErr;
        if (inValid) begin
            for (int k = 0; k < LANES; k++) begin
                if (contMask[k] || newMask[k]) begin
                    next_hD[LANES*8-1-8*k -: 8] = inData[LANES*8-1-8*k -: 8];
                    next_hC[LANES-1-k] = 1'b0;
                end else if (passThru && startMask[k]) begin
                    next_hD[LANES*8-1-8*k -: 8] = PRE_START;
                    next_hC[LANES-1-k] = 1'b1;
                end else if (passThru && preMask[k]) begin
                    next_hD[LANES*8-1-8*k -: 8] = sfdMask[k] ? PRE_SFD : PRE_BYTE;
                    next_hC[LANES-1-k] = 1'b0;
                end else begin
                    next_hD[LANES*8-1-8*k -: 8] = CH_IDLE;
                    next_hC[LANES-1-k] = 1'b1;
                end
                next_hLast[k] = hasLast && !late && (k == lastLane);
            end
            for (int w = 0; w < WORDS; w++) begin
                next_hFirst[w] = |headMask[w*WORD_LANES +: WORD_LANES];
                next_hPay[w] = |payMask[w*WORD_LANES +: WORD_LANES];
                next_hRunt[w] = runtNow && !late && ((lastLane >> WORD_SHIFT) == w);
            end
            next_hFcsV = endInfo.seen && !late;
            next_hFcsE = endInfo.seen && !late && !crcOk;
            next_hErr = errNow && !late;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            hD <= {LANES{CH_IDLE}};
            hC <= '1;
            hFirst <= '0;
            hPay <= '0;
            hLast <= '0;
            hRunt <= '0;
            hFcsV <= 1'b0;
            hFcsE <= 1'b0;
            hErr <= 1'b0;
        end else begin
            hD <= next_hD;
            hC <= next_hC;
            hFirst <= next_hFirst;
            hPay <= next_hPay;
            hLast <= next_hLast;
            hRunt <= next_hRunt;
            hFcsV <= next_hFcsV;
            hFcsE <= next_hFcsE;
            hErr <= next_hErr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage, word 0 and lane 0 mapped to the top bits

    logic [LANES*8-1:0] next_outData;
    logic [LANES-1:0] next_outCtl;
    logic [WORDS-1:0] next_outFirst;
    logic [LANES-1:0] next_outLast;
    logic [WORDS-1:0] next_outRunt;
    logic [WORDS-1:0] next_outPayload;
    logic next_outFcsError;
    logic next_outFcsValid;
    logic next_outValid;
    logic next_rxError;

    always_comb begin
        int heldLane;
        heldLane = LANES + lastLane;
        // stale contents stay put while valid is low; the client ignores them
        next_outData = outData;
        next_outCtl = outCtl;
        next_outFirst = outFirst;
        next_outLast = outLast;
        next_outRunt = outRunt;
        next_outPayload = outPayload;
        next_outFcsError = outFcsError;
        next_outFcsValid = outFcsValid;
        next_outValid = inValid;
        next_rxError = rxError;
        if (inValid) begin
            next_outData = hD;
            next_outCtl = hC;
            for (int k = 0; k < LANES; k++) begin
                next_outLast[LANES-1-k] = hLast[k] || (late && (k == heldLane));
            end
            for (int w = 0; w < WORDS; w++) begin
                next_outFirst[WORDS-1-w] = hFirst[w];
                next_outPayload[WORDS-1-w] = hPay[w];
                next_outRunt[WORDS-1-w] = hRunt[w] || (late && runtNow && ((heldLane >> WORD_SHIFT) == w));
            end
            next_outFcsValid = hFcsV || late;
            next_outFcsError = hFcsE || (late && !crcOk);
            next_rxError = hErr || (late && errNow);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            outData <= {LANES{CH_IDLE}};
            outCtl <= '1;
            outFirst <= '0;
            outLast <= '0;
            outRunt <= '0;
            outPayload <= '0;
            outFcsError <= 1'b0;
            outFcsValid <= 1'b0;
            outValid <= 1'b0;
            rxError <= 1'b0;
        end else begin
            outData <= next_outData;
            outCtl <= next_outCtl;
            outFirst <= next_outFirst;
            outLast <= next_outLast;
            outRunt <= next_outRunt;
            outPayload <= next_outPayload;
            outFcsError <= next_outFcsError;
            outFcsValid <= next_outFcsValid;
            outValid <= next_outValid;
            rxError <= next_rxError;
        end
    end

endmodule

//--- core/rxm_pkg.sv
// shared constants and types for the receive client output stage
package rxm_pkg;

    // bus geometry
    localparam int W_100G = 5;
    localparam int W_40G = 2;
    localparam int WORD_LANES = 8;
    localparam int WORD_SHIFT = 3;

    // cgmii characters
    localparam logic [7:0] CH_IDLE = 8'h07;
    localparam logic [7:0] CH_START = 8'hfb;
    localparam logic [7:0] CH_TERM = 8'hfd;
    localparam logic [7:0] CH_ERROR = 8'hfe;

    // preamble as shown to the client in pass-through mode
    localparam logic [7:0] PRE_START = 8'h55;
    localparam logic [7:0] PRE_BYTE = 8'h55;
    localparam logic [7:0] PRE_SFD = 8'hd5;
    localparam logic [2:0] PRE_CNT = 3'h7;

    // frame length limits, in bytes from first data through last fcs byte
    localparam logic [15:0] MIN_FRAME = 16'h0040;
    localparam logic [15:0] DECODE_MAX = 16'h0008;
    localparam logic [15:0] MAX_LEN_DEFAULT = 16'h05ee;
    localparam int LAST_BACK = 5;
    localparam logic [15:0] LAST_BACK_LEN = 16'h0005;

    // reflected crc-32, residue left after the fcs has been folded in
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } rxm_state_e;

    typedef struct packed {
        logic isStart;
        logic isTerm;
        logic isErr;
        logic isData;
        logic isIdle;
    } rxm_lane_s;

    typedef struct packed {
        logic seen;
        logic [7:0] lane;
        logic [15:0] len;
        logic isNew;
        logic err;
    } rxm_end_s;

endpackage

//--- core/rxm_lane_dec.sv
// classifies one cgmii byte lane
`timescale 1ns/1ps
module rxm_lane_dec
    import rxm_pkg::*;
(
    input wire logic [7:0] byteIn,
    input wire logic ctlIn,
    output rxm_lane_s lane
);

    assign lane.isData = !ctlIn;
    assign lane.isStart = ctlIn && (byteIn == CH_START);
    assign lane.isTerm = ctlIn && (byteIn == CH_TERM);
    assign lane.isErr = ctlIn && (byteIn == CH_ERROR);
    assign lane.isIdle = ctlIn && (byteIn == CH_IDLE);

endmodule

//--- core/rxm_crc32.sv
// folds the masked byte lanes of one bus word into a running crc-32
`timescale 1ns/1ps
module rxm_crc32
    import rxm_pkg::*;
#(
    parameter int LANES = 40
)(
    input wire logic [31:0] seed,
    input wire logic [LANES*8-1:0] bytes,
    input wire logic [LANES-1:0] mask,
    output logic [31:0] crc
);

    // lane 0 is the first byte in time and sits in the top byte of the bus
    always_comb begin
        logic [31:0] c;
        logic [7:0] b;
        c = seed;
        b = 8'h00;
        for (int k = 0; k < LANES; k++) begin
            if (mask[k]) begin
                b = bytes[LANES*8-1-8*k -: 8];
                for (int i = 0; i < 8; i++) begin
                    if (c[0] ^ b[i]) begin
                        c = (c >> 1) ^ CRC_POLY;
                    end else begin
                        c = c >> 1;
                    end
                end
            end
        end
        crc = c;
    end

endmodule

//--- testbench/rxm_client_out_checker.sv
// port-level assertions for the receive client output stage
`timescale 1ns/1ps
module rxm_client_out_checker
    import rxm_pkg::*;
#(
    parameter int WORDS = W_100G
)(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WORDS*64-1:0] inData,
    input wire logic [WORDS*8-1:0] inCtl,
    input wire logic inValid,
    input wire logic passThru,
    input wire logic [15:0] maxLen,
    input wire logic [WORDS*64-1:0] outData,
    input wire logic [WORDS*8-1:0] outCtl,
    input wire logic [WORDS-1:0] outFirst,
    input wire logic [WORDS*8-1:0] outLast,
    input wire logic [WORDS-1:0] outRunt,
    input wire logic [WORDS-1:0] outPayload,
    input wire logic outFcsError,
    input wire logic outFcsValid,
    input wire logic outValid,
    input wire logic rxError
);
    logic [WORDS-1:0] lastWord;
    logic [WORDS-1:0] idleWord;
    logic ptStart;
    always_comb begin
        for (int w = 0; w < WORDS; w++) begin
            lastWord[w] = |outLast[w*8 +: 8];
            idleWord[w] = (outData[w*64 +: 64] == {8{CH_IDLE}}) && (&outCtl[w*8 +: 8]);
        end
    end
    assign ptStart = inValid && passThru && inCtl[WORDS*8-1] && (inData[WORDS*64-1 -: 8] == CH_START);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    // reset must quiet the flags even while it is still applied
    reset_quiet_a: assert property (disable iff (1'b0) srst |=> !outValid && !outFirst && !outLast
        && !outRunt && !outPayload && !outFcsValid && !outFcsError && !rxError)
        else $error("flags not cleared by reset");
    valid_follow_a: assert property (!$past(srst) |-> outValid == $past(inValid))
        else $error("output valid does not follow input valid");
    fcs_pair_a: assert property (outValid && outFcsError |-> outFcsValid)
        else $error("crc error without crc valid");
    last_fcs_a: assert property (outValid && |outLast |-> outFcsValid && $onehot(outLast))
        else $error("last byte marker without a single crc result");
    crc_err_a: assert property (outValid && outFcsError |-> rxError)
        else $error("crc error not reported as receive error");
    runt_word_a: assert property (outValid && |outRunt |-> ((outRunt & ~lastWord) == '0) && rxError)
        else $error("runt flag off the last word or without receive error");
    payload_mark_a: assert property (outValid |-> ((outFirst | lastWord) & ~outPayload) == '0)
        else $error("frame word without payload bit");
    idle_lane_a: assert property (outValid |-> &(idleWord | outPayload))
        else $error("non-payload word not idle");
    pt_first_a: assert property (ptStart ##1 inValid |=> outFirst[WORDS-1] && outCtl[WORDS*8-1]
        && outCtl[WORDS*8-2 -: 7] == 7'h00 && outData[WORDS*64-1 -: 64] == {PRE_START, {6{PRE_BYTE}}, PRE_SFD})
        else $error("pass-through preamble word wrong");
    cover property (outValid && outFcsError);
    cover property (outValid && |outRunt);
    cover property (ptStart ##1 inValid ##1 outFirst[WORDS-1]);
endmodule

bind rxm_client_out rxm_client_out_checker #(.WORDS(WORDS)) chk_i (.core_clk(core_clk), .srst(srst),
    .inData(inData), .inCtl(inCtl), .inValid(inValid), .passThru(passThru), .maxLen(maxLen),
    .outData(outData), .outCtl(outCtl), .outFirst(outFirst), .outLast(outLast), .outRunt(outRunt),
    .outPayload(outPayload), .outFcsError(outFcsError), .outFcsValid(outFcsValid),
    .outValid(outValid), .rxError(rxError));

//--- testbench/rxm_client_sink.sv
// client logic model that records how each received frame was presented
`timescale 1ns/1ps
module rxm_client_sink
    import rxm_pkg::*;
#(
    parameter int WORDS = W_100G
)(
    input wire logic core_clk,
    input wire logic clr,
    input wire logic [WORDS*64-1:0] outData,
    input wire logic [WORDS*8-1:0] outCtl,
    input wire logic [WORDS-1:0] outFirst,
    input wire logic [WORDS*8-1:0] outLast,
    input wire logic [WORDS-1:0] outRunt,
    input wire logic outFcsError,
    input wire logic outFcsValid,
    input wire logic outValid,
    input wire logic rxError,
    output int nEnd,
    output int firstBit,
    output int lastDist,
    output logic [63:0] firstWord,
    output logic [7:0] firstCtl,
    output logic fcsBad,
    output logic runtSeen,
    output logic errSeen
);
    int pos;
    int firstPos;
    always @(posedge core_clk) begin
        if (clr) begin
            nEnd = 0;
            firstBit = -1;
            lastDist = -1;
            fcsBad = 1'b0;
            runtSeen = 1'b0;
            errSeen = 1'b0;
        end else if (outValid) begin
            for (int w = 0; w < WORDS; w++) begin
                if (outFirst[w]) begin
                    firstBit = w;
                    firstPos = pos + (WORDS - 1 - w) * 8;
                    firstWord = outData[w*64 +: 64];
                    firstCtl = outCtl[w*8 +: 8];
                end
            end
            // lane positions count across words, so spans are word-independent
            for (int b = 0; b < WORDS * 8; b++) begin
                if (outLast[b]) begin
                    lastDist = pos + WORDS * 8 - 1 - b - firstPos;
                end
            end
            if (outFcsValid) begin
                nEnd++;
                fcsBad = fcsBad | outFcsError;
            end
            runtSeen = runtSeen | (|outRunt);
            errSeen = errSeen | rxError;
            pos += WORDS * 8;
        end
    end
endmodule

//--- testbench/tb.sv
// self-checking bench for the receive client output stage
`timescale 1ns/1ps
module tb
    import rxm_pkg::*;
;
    localparam int W = W_100G;
    localparam int L = W * 8;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [W*64-1:0] inData = {L{CH_IDLE}};
    logic [L-1:0] inCtl = '1;
    logic inValid = 1'b0;
    logic passThru = 1'b0;
    logic [15:0] maxLen = MAX_LEN_DEFAULT;
    logic [W*64-1:0] outData;
    logic [L-1:0] outCtl;
    logic [W-1:0] outFirst;
    logic [L-1:0] outLast;
    logic [W-1:0] outRunt;
    logic [W-1:0] outPayload;
    logic outFcsError;
    logic outFcsValid;
    logic outValid;
    logic rxError;
    logic clr = 1'b0;
    int nEnd;
    int firstBit;
    int lastDist;
    logic [63:0] firstWord;
    logic [7:0] firstCtl;
    logic fcsBad;
    logic runtSeen;
    logic errSeen;
    int error_cnt = 0;
    int n_checks = 0;
    int gapWord = -1;
    logic [7:0] errChar = CH_ERROR;
    logic [7:0] qd[$];
    logic qc[$];

    rxm_client_out #(.WORDS(W)) dut (.core_clk(core_clk), .srst(srst), .inData(inData), .inCtl(inCtl),
        .inValid(inValid), .passThru(passThru), .maxLen(maxLen), .outData(outData), .outCtl(outCtl),
        .outFirst(outFirst), .outLast(outLast), .outRunt(outRunt), .outPayload(outPayload),
        .outFcsError(outFcsError), .outFcsValid(outFcsValid), .outValid(outValid), .rxError(rxError));
    rxm_client_sink #(.WORDS(W)) sink (.core_clk(core_clk), .clr(clr), .outData(outData), .outCtl(outCtl),
        .outFirst(outFirst), .outLast(outLast), .outRunt(outRunt), .outFcsError(outFcsError),
        .outFcsValid(outFcsValid), .outValid(outValid), .rxError(rxError), .nEnd(nEnd),
        .firstBit(firstBit), .lastDist(lastDist), .firstWord(firstWord), .firstCtl(firstCtl),
        .fcsBad(fcsBad), .runtSeen(runtSeen), .errSeen(errSeen));

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        c = c ^ {24'h0, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    task automatic push(input logic [7:0] d, input logic c);
        qd.push_back(d);
        qc.push_back(c);
    endtask

    // two idle words trail each frame so its last word leaves the pipeline
    task automatic flush();
        int n;
        n = 0;
        while (qd.size() % L != 0) push(CH_IDLE, 1'b1);
        repeat (2 * L) push(CH_IDLE, 1'b1);
        while (qd.size() > 0) begin
            @(negedge core_clk);
            if (n == gapWord) begin
                inValid = 1'b0;
                inData = ~inData;
                @(negedge core_clk);
            end
            for (int i = 0; i < L; i++) begin
                inData[(L-1-i)*8 +: 8] = qd.pop_front();
                inCtl[L-1-i] = qc.pop_front();
            end
            inValid = 1'b1;
            n++;
        end
        repeat (3) @(negedge core_clk);
    endtask

    task automatic frame(input int pre, input int len, input logic bad, input logic errc);
        logic [31:0] crc;
        logic [7:0] b;
        @(negedge core_clk);
        clr = 1'b1;
        @(negedge core_clk);
        clr = 1'b0;
        crc = CRC_INIT;
        repeat (pre) push(CH_IDLE, 1'b1);
        push(CH_START, 1'b1);
        repeat (6) push(PRE_BYTE, 1'b0);
        push(PRE_SFD, 1'b0);
        for (int i = 0; i < len - 4; i++) begin
            b = 8'(i * 3 + 1);
            crc = crc_step(crc, b);
            push((errc && i == 20) ? errChar : b, errc && i == 20);
        end
        crc = ~crc ^ {31'h0, bad};
        for (int i = 0; i < 4; i++) push(crc[i*8 +: 8], 1'b0);
        push(CH_TERM, 1'b1);
        flush();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(64'(outValid | |outFirst | |outLast | |outRunt | |outPayload | outFcsValid | outFcsError | rxError),
            64'h0);
        chk(64'(outData == {L{CH_IDLE}} && &outCtl), 64'h1);
    endtask

    task automatic t_starts(input logic pt);
        passThru = pt;
        for (int k = 0; k < W; k++) begin
            frame(k * 8, 64, 1'b0, 1'b0);
            chk(64'(firstBit), 64'(pt ? W - 1 - k : W - 1 - (k + 1) % W));
            chk(pt ? firstWord : 64'(firstWord[63:56]), pt ? 64'h55555555555555d5 : 64'h01);
            chk(64'(firstCtl), pt ? 64'h80 : 64'h0);
            chk(64'(lastDist), pt ? 64'h43 : 64'h3b);
            chk({fcsBad, runtSeen, errSeen, 29'h0, 32'(nEnd)}, 64'h1);
        end
        passThru = 1'b0;
    endtask

    task automatic t_lengths();
        int lens[5] = '{8, 9, 40, 52, 63};
        for (int i = 0; i < 5; i++) begin
            frame(0, lens[i], i == 2, 1'b0);
            chk({62'h0, runtSeen, errSeen}, {62'h0, lens[i] > 8, 1'b1});
            if (lens[i] >= 40) chk(64'(fcsBad), 64'(i == 2));
        end
    endtask

    task automatic t_errors();
        frame(0, 64, 1'b1, 1'b0);
        chk({62'h0, fcsBad, errSeen}, 64'h3);
        frame(8, 64, 1'b0, 1'b1);
        chk(64'(errSeen), 64'h1);
        // an idle inside the frame cuts it short: error, no crc result
        errChar = CH_IDLE;
        frame(0, 64, 1'b0, 1'b1);
        chk({errSeen, 31'h0, 32'(nEnd)}, 64'h8000000000000000);
        errChar = CH_ERROR;
        maxLen = 16'h0064;
        frame(0, 100, 1'b0, 1'b0);
        chk(64'(errSeen), 64'h0);
        frame(0, 101, 1'b0, 1'b0);
        chk(64'(errSeen), 64'h1);
        maxLen = MAX_LEN_DEFAULT;
    endtask

    // a rate gap inside the frame must not disturb its flags
    task automatic t_gap();
        gapWord = 1;
        frame(0, 64, 1'b0, 1'b0);
        gapWord = -1;
        chk({fcsBad, runtSeen, errSeen, 29'h0, 32'(lastDist)}, 64'h3b);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        t_reset();
        srst = 1'b0;
        @(negedge core_clk);
        inValid = 1'b1;
        t_starts(1'b0);
        t_starts(1'b1);
        t_lengths();
        t_errors();
        t_gap();
        summarize();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        summarize();
    end
endmodule
